// file: rtl/pin_ctrl_pkg.sv
// Package for the reset, interrupt and clock pin control block
package pin_ctrl_pkg;
    // APB register byte offsets
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_CLKCTL0 = 8'h04;
    localparam logic [7:0]  OFS_STAT    = 8'h08;
    localparam logic [7:0]  OFS_MASK    = 8'h0c;
    localparam logic [7:0]  OFS_PINSTAT = 8'h10;
    // Control register fields, then clock control 0 clock mode field bits
    localparam int          CTRL_GIM    = 0;
    localparam int          CTRL_PDPEN  = 1;
    localparam int          CTRL_IO2EN  = 2;
    localparam int          CTRL_IO3EN  = 3;
    localparam int          CTRL_IO2OUT = 4;
    localparam int          CTRL_IO3OUT = 5;
    localparam int          CKMD_HI     = 7;
    localparam int          CKMD_LO     = 6;
    // Reset values
    localparam logic [31:0] CTRL_RST    = 32'h0000_0003;
    localparam logic [31:0] CLKCTL0_RST = 32'h0000_00c0;
    localparam logic [31:0] MASK_RST    = 32'h0000_0000;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    // Status bit positions
    localparam int          ST_NMI = 0;
    localparam int          ST_X1  = 1;
    localparam int          ST_X2  = 2;
    localparam int          ST_X3  = 3;
    localparam int          ST_PDP = 4;
    localparam int          NEVT   = 5;
    // Synchronised pin bundle
    typedef struct packed {
        logic warm;
        logic por;
        logic nmi;
        logic x1;
        logic x2;
        logic x3;
        logic pdp;
        logic byp;
    } pins_t;
    typedef enum logic [1:0] {S_RESET, S_RUN} cpu_state_t;
endpackage

// file: rtl/reset_interrupt_clock_pins.sv
// Reset, interrupt, memory select and clock mode pin control
// Notes on behaviour
// RULE_01 - Warm reset held low stops execution and holds program counter at zero.
// RULE_02 - On reset release, fetching starts from program address zero.
// RULE_03 - Warm reset returns control and status registers to reset values.
// RULE_04 - Power-on reset does all that plus resets clock control; warm reset does not.
// RULE_05 - Select low fetches internal memory; high fetches external memory.
// RULE_06 - Non-maskable interrupt fires regardless of global interrupt mask.
// RULE_07 - Three user interrupts; second and third also general I/O.
// RULE_08 - Unmasked protect input low floats all compare outputs immediately.
// RULE_09 - Clock mode field bits 7:6 equal 1x selects crystal PLL mode.
// RULE_10 - Bypass input low takes clock straight from external clock input.
// RULE_11 - Crystal output floats while emulation off signal is low.
// RULE_12 - Board holds emulator pin 0 high for off condition under test reset.
// RULE_13 - Reset, interrupt and bypass inputs pass two-stage synchronisers.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module reset_interrupt_clock_pins
    import pin_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Board pins
    input  wire logic        warm_reset_n,
    input  wire logic        power_on_reset_n,
    input  wire logic        program_memory_source_select,
    input  wire logic        nmi_n,
    input  wire logic        ext_user_irq_1,
    input  wire logic        ext_user_irq_2,
    output logic             ext_user_irq_2_out,
    output logic             ext_user_irq_2_oe,
    input  wire logic        ext_user_irq_3,
    output logic             ext_user_irq_3_out,
    output logic             ext_user_irq_3_oe,
    input  wire logic        power_drive_protect_n,
    input  wire logic        oscillator_bypass_n,
    input  wire logic        emulation_off_n,
    output logic             crystal_out_oe,
    // Core side
    input  wire logic        fetchReq,
    output logic             cpuRun,
    output logic [15:0]      pc,
    output logic             fetchInternal,
    output logic             fetchExternal,
    output logic             pllMode,
    output logic             clockFromExternal,
    output logic             compareOutEnable,
    output logic             nmiTake,
    output logic             irq
);
    pins_t      sync1;
    pins_t      sync2;
    pins_t      raw;
    pins_t      prev;
    logic       warmRst;
    logic [31:0] ctrl;
    logic [31:0] clkctl0;
    logic [31:0] stat;
    logic [31:0] mask;
    logic [NEVT-1:0] evt;
    logic       wr;
    logic       rd;
    logic       pdpTrip;
    cpu_state_t state;

    // Raw pin bundle, active high for resets and interrupts
    assign raw = '{warm: ~warm_reset_n, por: ~power_on_reset_n, nmi: ~nmi_n,
                   x1: ext_user_irq_1, x2: ext_user_irq_2, x3: ext_user_irq_3,
                   pdp: ~power_drive_protect_n, byp: ~oscillator_bypass_n};

    // Two-stage synchronisers, first stage read only by second
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= raw;   // RULE_13
            sync2 <= sync1; // RULE_13
        end
    end

    // Previous synchronised values for edge detection
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prev <= '0;
        else
            prev <= sync2;
    end

    assign warmRst = sync2.warm | sync2.por;

    // Execution state and program counter
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= S_RESET;
            pc    <= RESET_VECTOR;
        end
        else if (warmRst)
        begin
            state <= S_RESET;       // RULE_01
            pc    <= RESET_VECTOR;  // RULE_01
        end
        else
        begin
            state <= S_RUN;         // RULE_02
            case (state)
                S_RESET: pc <= RESET_VECTOR; // RULE_02
                S_RUN:   pc <= fetchReq ? pc + 16'h0001 : pc;
                default: pc <= RESET_VECTOR;
            endcase
        end
    end
    assign cpuRun = (state == S_RUN) && !warmRst; // RULE_01

    // Memory source select
    assign fetchInternal = cpuRun && !program_memory_source_select; // RULE_05
    assign fetchExternal = cpuRun && program_memory_source_select;  // RULE_05

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;

    // Control register, reset by either reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ctrl <= CTRL_RST;
        else if (warmRst)
            ctrl <= CTRL_RST; // RULE_03
        else if (wr && paddr == OFS_CTRL)
            ctrl <= pwdata;
    end

    // Clock control 0, reset only by power-on reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            clkctl0 <= CLKCTL0_RST;
        else if (sync2.por)
            clkctl0 <= CLKCTL0_RST; // RULE_04
        else if (wr && !warmRst && paddr == OFS_CLKCTL0)
            clkctl0 <= pwdata;
    end

    // Interrupt mask register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mask <= MASK_RST;
        else if (warmRst)
            mask <= MASK_RST; // RULE_03
        else if (wr && paddr == OFS_MASK)
            mask <= pwdata;
    end

    // Falling NMI and protect pin edges and rising user interrupt pin edges (rising of active-high view) raise events
    assign evt[ST_NMI] = sync2.nmi & ~prev.nmi;
    assign evt[ST_X1]  = sync2.x1 & ~prev.x1;
    assign evt[ST_X2]  = sync2.x2 & ~prev.x2 & ~ctrl[CTRL_IO2EN]; // RULE_07
    assign evt[ST_X3]  = sync2.x3 & ~prev.x3 & ~ctrl[CTRL_IO3EN]; // RULE_07
    assign evt[ST_PDP] = sync2.pdp & ~prev.pdp;

    // Sticky status, write one to clear, set wins
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            stat <= '0;
        else if (warmRst)
            stat <= '0; // RULE_03
        else if (wr && paddr == OFS_STAT)
            stat <= (stat & ~pwdata) | {{(32-NEVT){1'b0}}, evt};
        else
            stat <= stat | {{(32-NEVT){1'b0}}, evt};
    end

    // NMI ignores the global mask; others gated by it
    assign nmiTake = stat[ST_NMI] && cpuRun; // RULE_06
    assign irq = stat[ST_NMI] || (!ctrl[CTRL_GIM] && |(stat[NEVT-1:1] & mask[NEVT-1:1])); // RULE_06

    // Protect trip floats compare outputs straight from pin
    assign pdpTrip = ctrl[CTRL_PDPEN] && !power_drive_protect_n; // RULE_08
    assign compareOutEnable = !pdpTrip && !warmRst;               // RULE_08

    // User interrupt pins 2 and 3 as general I/O
    assign ext_user_irq_2_out = ctrl[CTRL_IO2OUT]; // RULE_07
    assign ext_user_irq_2_oe  = ctrl[CTRL_IO2EN];  // RULE_07
    assign ext_user_irq_3_out = ctrl[CTRL_IO3OUT]; // RULE_07
    assign ext_user_irq_3_oe  = ctrl[CTRL_IO3EN];  // RULE_07

    // Clock source selection
    assign pllMode           = clkctl0[CKMD_HI];   // RULE_09
    assign clockFromExternal = sync2.byp;          // RULE_10
    assign crystal_out_oe    = emulation_off_n && !sync2.byp; // RULE_11

    // APB read data, registered
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                OFS_CTRL:    prdata <= ctrl;
                OFS_CLKCTL0: prdata <= clkctl0;
                OFS_STAT:    prdata <= stat;
                OFS_MASK:    prdata <= mask;
                OFS_PINSTAT: prdata <= {24'h000000, sync2};
                default:     prdata <= '0;
            endcase
        end
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(paddr inside {OFS_CTRL, OFS_CLKCTL0, OFS_STAT, OFS_MASK, OFS_PINSTAT});

    // Checks
    sequence s_warmHeld;
        sync2.warm ##1 sync2.warm;
    endsequence
    property p_pcZero;
        @(posedge clk) disable iff (!nrst) s_warmHeld |-> pc == RESET_VECTOR && !cpuRun;
    endproperty
    a_pcZero: assert property (p_pcZero) else $error("pc not zero in reset"); // RULE_01
    property p_startZero;
        @(posedge clk) disable iff (!nrst) $fell(warmRst) |-> pc == RESET_VECTOR ##1 cpuRun;
    endproperty
    a_startZero: assert property (p_startZero) else $error("bad start after reset"); // RULE_02
    property p_statClr;
        @(posedge clk) disable iff (!nrst) $past(warmRst) |-> stat == '0 && ctrl == CTRL_RST;
    endproperty
    a_statClr: assert property (p_statClr) else $error("reset left status"); // RULE_03
    property p_clkKeep;
        @(posedge clk) disable iff (!nrst) $past(sync2.warm) && !$past(sync2.por) |-> $stable(clkctl0);
    endproperty
    a_clkKeep: assert property (p_clkKeep) else $error("warm reset touched clock ctrl"); // RULE_04
    property p_memSel;
        @(posedge clk) disable iff (!nrst) cpuRun |-> fetchExternal == program_memory_source_select;
    endproperty
    a_memSel: assert property (p_memSel) else $error("wrong fetch source"); // RULE_05
    property p_nmi;
        @(posedge clk) disable iff (!nrst) !warmRst && evt[ST_NMI] |=> irq;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi lost"); // RULE_06
    property p_pdp;
        @(posedge clk) disable iff (!nrst) ctrl[CTRL_PDPEN] && !power_drive_protect_n |-> !compareOutEnable;
    endproperty
    a_pdp: assert property (p_pdp) else $error("compare outputs not floated"); // RULE_08
    property p_off;
        @(posedge clk) disable iff (!nrst) !emulation_off_n |-> !crystal_out_oe;
    endproperty
    a_off: assert property (p_off) else $error("crystal out driven in off"); // RULE_11
    property p_sync;
        @(posedge clk) disable iff (!nrst) sync2.byp == $past(~oscillator_bypass_n, 2) || $past(!nrst, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("sync depth wrong"); // RULE_13
    // Further checks on reset, interrupt, pin and clock behaviour
    property p_runStop;
        @(posedge clk) disable iff (!nrst) sync2.warm |=> !cpuRun;
    endproperty
    a_runStop: assert property (p_runStop) else $error("ran during warm reset"); // RULE_01
    property p_clkWrBlock;
        @(posedge clk) disable iff (!nrst) $past(warmRst) |-> $stable(clkctl0) || $past(sync2.por);
    endproperty
    a_clkWrBlock: assert property (p_clkWrBlock) else $error("clock ctrl written in reset"); // RULE_04
    property p_porClk;
        @(posedge clk) disable iff (!nrst) $past(sync2.por) |-> clkctl0 == CLKCTL0_RST && pllMode;
    endproperty
    a_porClk: assert property (p_porClk) else $error("power-on reset left clock ctrl"); // RULE_04
    property p_irqMask;
        @(posedge clk) disable iff (!nrst) ctrl[CTRL_GIM] && !stat[ST_NMI] |-> !irq;
    endproperty
    a_irqMask: assert property (p_irqMask) else $error("masked interrupt raised"); // RULE_06
    property p_sticky;
        @(posedge clk) disable iff (!nrst) !warmRst && evt[ST_X1] |=> stat[ST_X1];
    endproperty
    a_sticky: assert property (p_sticky) else $error("user interrupt lost"); // RULE_07
    property p_gpio2;
        @(posedge clk) disable iff (!nrst) ctrl[CTRL_IO2EN] |-> ext_user_irq_2_oe && !evt[ST_X2];
    endproperty
    a_gpio2: assert property (p_gpio2) else $error("pin 2 not in io mode"); // RULE_07
    property p_gpio3;
        @(posedge clk) disable iff (!nrst) ctrl[CTRL_IO3EN] |-> ext_user_irq_3_oe && !evt[ST_X3];
    endproperty
    a_gpio3: assert property (p_gpio3) else $error("pin 3 not in io mode"); // RULE_07
    property p_cmpReset;
        @(posedge clk) disable iff (!nrst) warmRst |-> !compareOutEnable;
    endproperty
    a_cmpReset: assert property (p_cmpReset) else $error("compare outputs driven in reset"); // RULE_08
    property p_bypass;
        @(posedge clk) disable iff (!nrst) sync2.byp |-> clockFromExternal && !crystal_out_oe;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not honoured"); // RULE_10
endmodule // reset_interrupt_clock_pins

// file: sim/board_model.sv
// Board-side model driving reset, interrupt, select and clock pins
`timescale 1ns/100ps
module board_model
(
    // Clock and wanted pin levels
    input  wire logic       clk,
    input  wire logic [9:0] cmd,
    // Device drive of the shared interrupt pins
    input  wire logic       io2Out,
    input  wire logic       io2Oe,
    input  wire logic       io3Out,
    input  wire logic       io3Oe,
    // Resolved pin levels
    output logic [9:0]      pinLvl,
    output logic            emuPin0
);
    logic [9:0] drv = 10'h1c7;
    // Board pins change just after the rising edge
    always_ff @(posedge clk)
        drv <= cmd;
    // Device drive wins on a shared pin
    always_comb
    begin
        pinLvl    = drv;
        pinLvl[4] = io2Oe ? io2Out : drv[4];
        pinLvl[5] = io3Oe ? io3Out : drv[5];
    end
    // Held high so the off condition can act
    assign emuPin0 = 1'b1;
endmodule // board_model

// file: sim/reset_interrupt_clock_pins_tb.sv
// Testbench for the reset, interrupt and clock pin block
`timescale 1ns/100ps
module reset_interrupt_clock_pins_tb;
    import pin_ctrl_pkg::*;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, fetchReq = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [9:0] cmd = 10'h1c7, p;
    logic pready, pslverr, cpuRun, fetchInternal, fetchExternal, pllMode, clockFromExternal;
    logic compareOutEnable, nmiTake, irq, crystal_out_oe, o2, e2, o3, e3;
    logic [15:0] pc;
    int error_cnt = 0, compares = 0;
    always #4 clk = ~clk;
    board_model i_board_model (.clk, .cmd, .io2Out(o2), .io2Oe(e2), .io3Out(o3), .io3Oe(e3), .pinLvl(p),
        .emuPin0());
    reset_interrupt_clock_pins i_reset_interrupt_clock_pins (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .warm_reset_n(p[0]), .power_on_reset_n(p[1]), .nmi_n(p[2]),
        .ext_user_irq_1(p[3]), .ext_user_irq_2(p[4]), .ext_user_irq_2_out(o2), .ext_user_irq_2_oe(e2),
        .ext_user_irq_3(p[5]), .ext_user_irq_3_out(o3), .ext_user_irq_3_oe(e3), .power_drive_protect_n(p[6]),
        .oscillator_bypass_n(p[7]), .emulation_off_n(p[8]), .program_memory_source_select(p[9]),
        .crystal_out_oe, .fetchReq, .cpuRun, .pc, .fetchInternal, .fetchExternal, .pllMode,
        .clockFromExternal, .compareOutEnable, .nmiTake, .irq);
    // Wait edges, then let their updates land
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Compare one result
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        #1;
    endtask
    // Read and compare a register
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(rd, e);
    endtask
    task done(input string s);
        $display("test %s finished", s);
    endtask
    task t_regs;
        rdchk(OFS_CTRL, CTRL_RST);
        rdchk(OFS_CLKCTL0, CLKCTL0_RST);
        rdchk(OFS_MASK, MASK_RST);
        rdchk(OFS_PINSTAT, 32'h0);
        chk(pready, 1);
        rdchk(8'h14, 32'h0);
        chk(err, 1);
        chk(pllMode, 1);
        done("regs");
    endtask
    task t_reset;
        int n;
        apb(1, OFS_CLKCTL0, 32'h0);
        apb(1, OFS_CTRL, 32'h0);
        cmd[0] <= 0;
        cyc(5);
        chk({cpuRun, pc}, 0);
        cmd[0] <= 1;
        n = 0;
        do cyc(1); while (cpuRun !== 1'b1 && ++n < 20);
        chk({cpuRun, pc}, 17'h10000);
        rdchk(OFS_CTRL, CTRL_RST);
        rdchk(OFS_CLKCTL0, 32'h0);
        chk(pllMode, 0);
        apb(1, OFS_CLKCTL0, 32'h80);
        chk(pllMode, 1);
        cmd[1] <= 0;
        cyc(5);
        cmd[1] <= 1;
        cyc(5);
        rdchk(OFS_CLKCTL0, CLKCTL0_RST);
        done("reset");
    endtask
    task t_memsel;
        fetchReq <= 1;
        cmd[9] <= 1;
        cyc(3);
        chk({fetchInternal, fetchExternal}, 2'b01);
        chk(pc !== 16'h0, 1);
        cmd[9] <= 0;
        cyc(2);
        chk({fetchInternal, fetchExternal}, 2'b10);
        done("memsel");
    endtask
    task t_nmi;
        cmd[2] <= 0;
        cyc(5);
        chk({nmiTake, irq}, 2'b11);
        cmd[2] <= 1;
        rdchk(OFS_STAT, 32'h1);
        apb(1, OFS_STAT, 32'h1);
        cyc(2);
        chk(irq, 0);
        done("nmi");
    endtask
    task t_irq;
        apb(1, OFS_CTRL, 32'h0);
        apb(1, OFS_MASK, 32'he);
        for (int i = 1; i < 4; i++)
        begin
            cmd[2 + i] <= 1;
            cyc(5);
            chk(irq, 1);
            cmd[2 + i] <= 0;
            rdchk(OFS_STAT, 32'h1 << i);
            apb(1, OFS_STAT, 32'h1f);
            cyc(2);
            chk(irq, 0);
        end
        apb(1, OFS_MASK, 32'h0);
        cmd[3] <= 1;
        cyc(5);
        chk(irq, 0);
        apb(1, OFS_CTRL, 32'h14);
        chk({e2, o2}, 2'b11);
        apb(1, OFS_CTRL, 32'h28);
        chk({e3, o3, e2}, 3'b110);
        apb(1, OFS_CTRL, 32'h0);
        apb(1, OFS_STAT, 32'h1f);
        cmd[3] <= 0;
        done("irq");
    endtask
    task t_protect;
        cmd[6] <= 0;
        cyc(5);
        chk(compareOutEnable, 1);
        cmd[6] <= 1;
        cyc(3);
        apb(1, OFS_CTRL, 32'h2);
        cmd[6] <= 0;
        cyc(4);
        chk(compareOutEnable, 0);
        cmd[6] <= 1;
        done("protect");
    endtask
    task t_clock;
        cmd[7] <= 0;
        cyc(5);
        chk({clockFromExternal, crystal_out_oe}, 2'b10);
        cmd[7] <= 1;
        cyc(5);
        chk({clockFromExternal, crystal_out_oe}, 2'b01);
        cmd[8] <= 0;
        cyc(2);
        chk(crystal_out_oe, 0);
        done("clock");
    endtask
    task give_verdict;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        cyc(6);
        nrst <= 1;
        cyc(6);
        t_regs;
        t_reset;
        t_memsel;
        t_nmi;
        t_irq;
        t_protect;
        t_clock;
        give_verdict;
    end
    // Watchdog against a hang
    initial
    begin
        #200000;
        error_cnt++;
        give_verdict;
    end
endmodule // reset_interrupt_clock_pins_tb
